/* File: rtl/glob_regs_defs.vh */
// Purpose: Offsets, field positions, reset values and timing counts of the
//          global control register bank.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef GLOB_REGS_DEFS_VH
`define GLOB_REGS_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses on the 10-bit address bus).
// ****************************************************************
`define OFS_DEVICE_IDENTITY     10'h000
`define OFS_GLOBAL_CONTROL_ONE  10'h002
`define OFS_GLOBAL_CONTROL_TWO  10'h004
`define OFS_PIN_FUNCTION_SELECT 10'h010
`define OFS_IRQ_SUMMARY         10'h020
`define OFS_IRQ_SUMMARY_ENABLE  10'h022
`define OFS_GLOBAL_LIVE_STATUS  10'h028
`define OFS_GLOBAL_LATCHED      10'h02A
`define OFS_GLOBAL_STATUS_EN    10'h02C
`define OFS_PIN_LEVEL_READBACK  10'h038

// ****************************************************************
// Field positions in global_control_one.
// ****************************************************************
`define CR1_RESET_BIT           0
`define CR1_DATAPATH_RESET      1
`define CR1_UPDATE_REQUEST      3
`define CR1_UPDATE_MODE_LO      4
`define CR1_UPDATE_MODE_HI      5
`define CR1_ERR_SRC_SELECT      6
`define CR1_ERR_TRIGGER         7
`define CR1_SECOND_OUT_EN       8
`define CR1_SECOND_SRC_LO       9
`define CR1_SECOND_SRC_HI       11

// ****************************************************************
// Field positions in global_control_two.
// ****************************************************************
`define CR2_BROADCAST_WRITE     0
`define CR2_CLEAR_ON_READ       1
`define CR2_IRQ_PIN_MODE        4
`define CR2_CLOCK_D_OUTPUT_LOW_FREQ       5
`define CR2_CLOCK_ADAPTER_LO             8
`define CR2_CLOCK_ADAPTER_HI             14
`define CR2_CLOCK_ADAPTER_CLOCK_D_OUTPUT_BIT       11

// ****************************************************************
// Reset values and writable masks.
// ****************************************************************
`define RST_GLOBAL_CONTROL_ONE  16'h0002
`define RST_GLOBAL_CONTROL_TWO  16'h0000
`define RST_PIN_FUNCTION_SELECT 16'h0000
`define RST_IRQ_SUMMARY_ENABLE  16'h0000
`define RST_GLOBAL_STATUS_EN    16'h0000
`define MSK_GLOBAL_CONTROL_ONE  16'h0FFB
`define MSK_GLOBAL_CONTROL_TWO  16'h7F33
`define MSK_IRQ_SUMMARY_ENABLE  16'h001F
`define MSK_GLOBAL_STATUS_EN    16'h0007

// ****************************************************************
// Pin function codes.
// ****************************************************************
`define PIN_FN_INPUT            2'h0
`define PIN_FN_LOS              2'h1
`define PIN_FN_LOW              2'h2
`define PIN_FN_HIGH             2'h3

// ****************************************************************
// Timing.
// ****************************************************************
`define CLK_PERIOD_NS           100
`define MIN_RESET_HOLD_NS       100
`define MIN_RESET_HOLD_CYC      \
    ((`MIN_RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECOND_DIV_DEFAULT      32'h000003E8

`endif

/* File: rtl/second_ref_gen.v */
// Purpose: One-second reference from the selected source clock tick.
// Assumes: Source ticks arrive as one-cycle pulses synchronous to I_MCLK.
// Notes:   One divider shared by all sources; the divisors are parameters.
`include "glob_regs_defs.vh"

module second_ref_gen #(
    parameter [31:0] DIV_DS3  = `SECOND_DIV_DEFAULT,
    parameter [31:0] DIV_E3   = `SECOND_DIV_DEFAULT,
    parameter [31:0] DIV_STS1 = `SECOND_DIV_DEFAULT,
    parameter [31:0] DIV_TX   = `SECOND_DIV_DEFAULT
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire [2:0]  i_source,
    input  wire [2:0]  i_ref_tick,
    input  wire [3:0]  i_tx_tick,
    output reg         o_level,
    output reg         o_pulse
);

    // ****************************************************************
    // Source selection.
    // ****************************************************************
    reg        tick;    // Selected source tick.
    reg [31:0] limit;   // Divisor for the selected source.
    reg [31:0] cnt_q;   // Ticks counted in the current second.
    reg [2:0]  src_q;   // Source seen last cycle, to restart on change.

    // Picks the tick and divisor that belong to the selected source.
    always @* begin
        tick  = 1'b0;
        limit = DIV_TX;
        case (i_source)
            3'h1: begin
                tick  = i_ref_tick[0];
                limit = DIV_DS3;
            end
            3'h2: begin
                tick  = i_ref_tick[1];
                limit = DIV_E3;
            end
            3'h3: begin
                tick  = i_ref_tick[2];
                limit = DIV_STS1;
            end
            3'h4: tick = i_tx_tick[0];
            3'h5: tick = i_tx_tick[1];
            3'h6: tick = i_tx_tick[2];
            3'h7: tick = i_tx_tick[3];
            default: tick = 1'b0;
        endcase
    end

    // ****************************************************************
    // Divider.
    // ****************************************************************
    // Counts ticks; the level is high for the first half of each second
    // and one pulse marks its start.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q   <= 32'h00000000;
            src_q   <= 3'h0;
            o_level <= 1'b0;
            o_pulse <= 1'b0;
        end else begin
            src_q   <= i_source;
            o_pulse <= 1'b0;
            if (i_source == 3'h0 || i_source != src_q) begin
                cnt_q   <= 32'h00000000;
                o_level <= 1'b0;
            end else if (tick) begin
                if (cnt_q >= limit - 32'h00000001) begin
                    cnt_q   <= 32'h00000000;
                    o_level <= 1'b1;
                    o_pulse <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 32'h00000001;
                    if (cnt_q == (limit >> 1)) begin
                        o_level <= 1'b0;
                    end
                end
            end
        end
    end

endmodule

/* File: rtl/pin_mux.v */
// Purpose: Drive of the eight general-purpose pins from their selects.
// Assumes: Pin order is B1..B4 in bits 3:0 and A1..A4 in bits 7:4.
// Notes:   Overrides for B1, B2 and B3 are resolved here.
`include "glob_regs_defs.vh"

module pin_mux (
    input  wire [15:0] i_select,
    input  wire [3:0]  i_los,
    input  wire        i_second_out_en,
    input  wire        i_second_level,
    input  wire        i_b2_is_input,
    input  wire        i_b1_is_input,
    output wire [7:0]  o_pin_out,
    output wire [7:0]  o_pin_oe
);

    // ****************************************************************
    // Per-pin function decode.
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : pin
            wire [1:0] fn;     // This pin's function select.
            wire       base_o; // Level from the select alone.
            wire       base_e; // Enable from the select alone.
            assign fn     = i_select[2*g+1:2*g];
            assign base_o = (fn == `PIN_FN_HIGH) |
                            ((fn == `PIN_FN_LOS) & i_los[g % 4]);
            assign base_e = (fn != `PIN_FN_INPUT);
            if (g == 2) begin : b3
                assign o_pin_out[g] = i_second_out_en ? i_second_level
                                                      : base_o;
                assign o_pin_oe[g]  = i_second_out_en | base_e;
            end else if (g == 1) begin : b2
                assign o_pin_out[g] = base_o;
                assign o_pin_oe[g]  = base_e & ~i_b2_is_input;
            end else if (g == 0) begin : b1
                assign o_pin_out[g] = base_o;
                assign o_pin_oe[g]  = base_e & ~i_b1_is_input;
            end else begin : plain
                assign o_pin_out[g] = base_o;
                assign o_pin_oe[g]  = base_e;
            end
        end
    endgenerate

endmodule

/* File: rtl/global_control_registers.v */
// Purpose: Global control and status register bank of the line interface.
// Assumes: Parallel 16-bit bus synchronous to I_MCLK; strobes last one cycle.
// Notes:   Port blocks, clock adapter and counters sit outside this bank.
`include "glob_regs_defs.vh"

module global_control_registers #(
    parameter [3:0]  REVISION_ID = 4'h1,     // Arbitrary value.
    parameter [11:0] PART_CODE   = 12'h5A5,  // Arbitrary value.
    parameter [31:0] DIV_DS3     = `SECOND_DIV_DEFAULT,
    parameter [31:0] DIV_E3      = `SECOND_DIV_DEFAULT,
    parameter [31:0] DIV_STS1    = `SECOND_DIV_DEFAULT,
    parameter [31:0] DIV_TX      = `SECOND_DIV_DEFAULT
) (
    input  wire        I_MCLK,
    input  wire        I_RST,
    input  wire        I_CS,
    input  wire        I_WR,
    input  wire        I_RD,
    input  wire [9:0]  I_ADDR,
    input  wire [15:0] I_WDATA,
    output reg  [15:0] O_RDATA,
    input  wire [2:0]  I_REF_TICK,
    input  wire [3:0]  I_TX_TICK,
    input  wire [3:0]  I_LOS,
    input  wire [3:0]  I_PORT_IRQ,
    input  wire        I_PORTS_UPDATED,
    input  wire        I_CLOCK_ADAPTER_UNLOCK,
    input  wire [7:0]  I_PIN_IN,
    output wire [7:0]  O_PIN_OUT,
    output wire [7:0]  O_PIN_OE,
    output wire        O_IRQ_OUT,
    output wire        O_IRQ_OE,
    output reg         O_ERROR_INSERT,
    output reg         O_UPDATE_STROBE,
    output wire        O_UPDATE_LEVEL,
    output wire        O_DATAPATH_RESET,
    output wire        O_GLOBAL_RESET,
    output wire [6:0]  O_CLOCK_ADAPTER,
    output wire        O_CLOCK_D_LOW_FREQ,
    output wire        O_BROADCAST_WRITE,
    output wire        O_CLEAR_ON_READ
);

    // ****************************************************************
    // Register state.
    // ****************************************************************
    reg  [15:1] ctl1_q;        // global_control_one above the reset bit.
    reg         rst_bit_q;     // Register reset bit, cleared by pin or a write of zero.
    wire [15:0] ctl1_rst;      // Reset value of global_control_one.
    wire [15:0] ctl1_wr;       // Masked write data of global_control_one.
    reg  [15:0] ctl2_q;        // global_control_two.
    reg  [15:0] pinsel_q;      // pin_function_select.
    reg  [15:0] sum_en_q;      // interrupt_summary_enable.
    reg  [15:0] st_en_q;       // global_status_enable.
    reg  [2:0]  latched_q;     // Latched: unlock, second, update done.
    reg  [2:0]  latched_d;     // Next latched value.
    reg         err_src_q;     // Error trigger source, last cycle.
    reg         upd_src_q;     // Update trigger source, last cycle.
    reg         done_q;        // Update complete status, last cycle.
    reg         unlock_q;      // Clock adapter unlock, last cycle.
    reg  [15:0] rdata_d;       // Next read data.
    wire        wr_en;         // Write strobe for this bank.
    wire        rd_en;         // Read strobe for this bank.
    wire        soft_reset;    // Combined register and pin reset.
    wire        sec_level;     // One-second reference level.
    wire        sec_pulse;     // One-second reference start pulse.
    wire [1:0]  upd_mode;      // Update mode field.
    wire        err_src;       // Selected error trigger source.
    wire        upd_src;       // Selected update trigger source.
    wire        done;          // Update complete status.
    wire        glob_sum;      // Any enabled latched global bit.
    wire [4:0]  summary;       // Interrupt summary bits.
    wire [7:0]  pin_level;     // Pin levels as seen on the pads.

    assign wr_en = I_CS & I_WR;
    assign rd_en = I_CS & I_RD;
    // Full-width copies, so the stored field is cut on purpose.
    assign ctl1_rst = `RST_GLOBAL_CONTROL_ONE;
    assign ctl1_wr  = I_WDATA & `MSK_GLOBAL_CONTROL_ONE;

    // ****************************************************************
    // Reset combination.
    // ****************************************************************
    // The register reset bit resets everything but itself and the read data register.
    assign soft_reset       = I_RST | rst_bit_q;
    assign O_GLOBAL_RESET   = soft_reset;
    assign O_DATAPATH_RESET = soft_reset |
                              ctl1_q[`CR1_DATAPATH_RESET];

    // ****************************************************************
    // Reset bit: cleared by the hardware pin or by writing zero to it.
    // ****************************************************************
    // Holding time is software's duty; one cycle already meets it.
    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            rst_bit_q <= 1'b0;
        end else if (wr_en && I_ADDR == `OFS_GLOBAL_CONTROL_ONE) begin
            rst_bit_q <= I_WDATA[`CR1_RESET_BIT];
        end
    end

    // ****************************************************************
    // Control registers, reset by the combined reset.
    // ****************************************************************
    // Writes store masked data, pin_function_select whole; reserved bits stay zero.
    always @(posedge I_MCLK or posedge soft_reset) begin
        if (soft_reset) begin
            ctl1_q       <= ctl1_rst[15:1];
            ctl2_q       <= `RST_GLOBAL_CONTROL_TWO;
            pinsel_q     <= `RST_PIN_FUNCTION_SELECT;
            sum_en_q     <= `RST_IRQ_SUMMARY_ENABLE;
            st_en_q      <= `RST_GLOBAL_STATUS_EN;
        end else if (wr_en) begin
            case (I_ADDR)
                `OFS_GLOBAL_CONTROL_ONE: begin
                    ctl1_q <= ctl1_wr[15:1];
                end
                `OFS_GLOBAL_CONTROL_TWO: begin
                    ctl2_q <= I_WDATA & `MSK_GLOBAL_CONTROL_TWO;
                end
                `OFS_PIN_FUNCTION_SELECT: begin
                    pinsel_q <= I_WDATA;
                end
                `OFS_IRQ_SUMMARY_ENABLE: begin
                    sum_en_q <= I_WDATA & `MSK_IRQ_SUMMARY_ENABLE;
                end
                `OFS_GLOBAL_STATUS_EN: begin
                    st_en_q <= I_WDATA & `MSK_GLOBAL_STATUS_EN;
                end
                default: begin
                    ctl2_q <= ctl2_q;
                end
            endcase
        end
    end

    // ****************************************************************
    // Global control outputs.
    // ****************************************************************
    assign O_CLOCK_ADAPTER    = ctl2_q[`CR2_CLOCK_ADAPTER_HI:`CR2_CLOCK_ADAPTER_LO];
    assign O_CLOCK_D_LOW_FREQ = ctl2_q[`CR2_CLOCK_ADAPTER_CLOCK_D_OUTPUT_BIT] &
                                ctl2_q[`CR2_CLOCK_D_OUTPUT_LOW_FREQ];
    assign O_BROADCAST_WRITE  = ctl2_q[`CR2_BROADCAST_WRITE];
    assign O_CLEAR_ON_READ    = ctl2_q[`CR2_CLEAR_ON_READ];
    assign upd_mode = ctl1_q[`CR1_UPDATE_MODE_HI:`CR1_UPDATE_MODE_LO];

    // ****************************************************************
    // One-second reference.
    // ****************************************************************
    second_ref_gen #(
        .DIV_DS3  (DIV_DS3),
        .DIV_E3   (DIV_E3),
        .DIV_STS1 (DIV_STS1),
        .DIV_TX   (DIV_TX)
    ) u_second (
        .i_clk      (I_MCLK),
        .i_rst      (soft_reset),
        .i_source   (ctl1_q[`CR1_SECOND_SRC_HI:`CR1_SECOND_SRC_LO]),
        .i_ref_tick (I_REF_TICK),
        .i_tx_tick  (I_TX_TICK),
        .o_level    (sec_level),
        .o_pulse    (sec_pulse)
    );

    // ****************************************************************
    // General-purpose pins.
    // ****************************************************************
    pin_mux u_pins (
        .i_select        (pinsel_q),
        .i_los           (I_LOS),
        .i_second_out_en (ctl1_q[`CR1_SECOND_OUT_EN]),
        .i_second_level  (sec_level),
        .i_b2_is_input   (ctl1_q[`CR1_ERR_SRC_SELECT]),
        .i_b1_is_input   (upd_mode == 2'h1),
        .o_pin_out       (O_PIN_OUT),
        .o_pin_oe        (O_PIN_OE)
    );

    // Pads read back their own drive when enabled, else the outside.
    assign pin_level = (O_PIN_OE & O_PIN_OUT) | (~O_PIN_OE & I_PIN_IN);

    // ****************************************************************
    // Error insertion and update triggers.
    // ****************************************************************
    assign err_src = ctl1_q[`CR1_ERR_SRC_SELECT] ? I_PIN_IN[1]
                   : ctl1_q[`CR1_ERR_TRIGGER];
    assign upd_src = upd_mode[1] ? sec_level
                   : (upd_mode[0] ? I_PIN_IN[0]
                   : ctl1_q[`CR1_UPDATE_REQUEST]);
    assign O_UPDATE_LEVEL = upd_src;
    // Complete only while the request stays high; low clears it.
    assign done = I_PORTS_UPDATED & upd_src;

    // Rising edges make one-cycle strobes; the ports own the counters,
    // including loading one when an increment meets the reset.
    always @(posedge I_MCLK or posedge soft_reset) begin
        if (soft_reset) begin
            err_src_q       <= 1'b0;
            upd_src_q       <= 1'b0;
            O_ERROR_INSERT  <= 1'b0;
            O_UPDATE_STROBE <= 1'b0;
        end else begin
            err_src_q       <= err_src;
            upd_src_q       <= upd_src;
            O_ERROR_INSERT  <= err_src & ~err_src_q &
                               ~O_DATAPATH_RESET;
            O_UPDATE_STROBE <= upd_src & ~upd_src_q &
                               ~O_DATAPATH_RESET;
        end
    end

    // ****************************************************************
    // Latched global status.
    // ****************************************************************
    // Events set; reads clear when clear-on-read is set, else writes of one; a set wins a clear.
    always @* begin
        latched_d = latched_q;
        if (O_CLEAR_ON_READ) begin
            if (rd_en && I_ADDR == `OFS_GLOBAL_LATCHED) begin
                latched_d = 3'h0;
            end
        end else if (wr_en && I_ADDR == `OFS_GLOBAL_LATCHED) begin
            latched_d = latched_q & ~I_WDATA[2:0];
        end
        latched_d = latched_d |
                    {I_CLOCK_ADAPTER_UNLOCK & ~unlock_q, sec_pulse, done & ~done_q};
    end

    // Stores the latched bits and the previous sources of their events.
    always @(posedge I_MCLK or posedge soft_reset) begin
        if (soft_reset) begin
            latched_q <= 3'h0;
            done_q    <= 1'b0;
            unlock_q  <= 1'b0;
        end else begin
            latched_q <= latched_d;
            done_q    <= done;
            unlock_q  <= I_CLOCK_ADAPTER_UNLOCK;
        end
    end

    // ****************************************************************
    // Interrupt summary and pin.
    // ****************************************************************
    assign glob_sum  = |(latched_q & st_en_q[2:0]);
    assign summary   = {I_PORT_IRQ, glob_sum};
    // Low while any enabled source is active, else float or high.
    assign O_IRQ_OUT = ~(|(summary & sum_en_q[4:0]));
    assign O_IRQ_OE  = ~O_IRQ_OUT | ctl2_q[`CR2_IRQ_PIN_MODE];

    // ****************************************************************
    // Read path.
    // ****************************************************************
    // Unmapped offsets read zero.
    always @* begin
        case (I_ADDR)
            `OFS_DEVICE_IDENTITY:     rdata_d = {REVISION_ID, PART_CODE};
            `OFS_GLOBAL_CONTROL_ONE:  rdata_d = {ctl1_q, rst_bit_q};
            `OFS_GLOBAL_CONTROL_TWO:  rdata_d = ctl2_q;
            `OFS_PIN_FUNCTION_SELECT: rdata_d = pinsel_q;
            `OFS_IRQ_SUMMARY:         rdata_d = {11'h000, summary};
            `OFS_IRQ_SUMMARY_ENABLE:  rdata_d = sum_en_q;
            `OFS_GLOBAL_LIVE_STATUS:  rdata_d = {13'h0000, I_CLOCK_ADAPTER_UNLOCK,
                                                 1'b0, done};
            `OFS_GLOBAL_LATCHED:      rdata_d = {13'h0000, latched_q};
            `OFS_GLOBAL_STATUS_EN:    rdata_d = st_en_q;
            `OFS_PIN_LEVEL_READBACK:  rdata_d = {8'h00, pin_level};
            default:                  rdata_d = 16'h0000;
        endcase
    end

    // Read data register, loaded on a read strobe.
    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= 16'h0000;
        end else if (rd_en) begin
            O_RDATA <= rdata_d;
        end
    end

endmodule

/* File: test/glob_regs_properties.sv */
// Purpose: Port timing checks of the global control register bank.
// Assumes: Bound to the bank's top module; one clock domain.
// Notes:   Write effects are expected one edge after the write is taken.
module glob_regs_chk (
    input wire        I_MCLK,
    input wire        I_RST,
    input wire        I_CS,
    input wire        I_WR,
    input wire [9:0]  I_ADDR,
    input wire [15:0] I_WDATA,
    input wire [7:0]  O_PIN_OE,
    input wire        O_IRQ_OUT,
    input wire        O_IRQ_OE,
    input wire        O_ERROR_INSERT,
    input wire        O_UPDATE_STROBE,
    input wire        O_DATAPATH_RESET,
    input wire        O_GLOBAL_RESET,
    input wire        O_CLOCK_D_LOW_FREQ,
    input wire        O_CLEAR_ON_READ
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // Write decodes and properties.
    // ********************
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    // Taken writes; the later words only count outside a global reset.
    wire w1 = I_CS & I_WR & (I_ADDR == 10'h002);
    wire w2 = I_CS & I_WR & ~O_GLOBAL_RESET & (I_ADDR == 10'h004);
    wire w3 = I_CS & I_WR & ~O_GLOBAL_RESET & (I_ADDR == 10'h010);
    property p_grst; w1 & I_WDATA[0] |=> O_GLOBAL_RESET; endproperty
    a_grst: assert property (p_grst) else $error("global reset");
    property p_dpr;
        w1 & ~O_GLOBAL_RESET & ~I_WDATA[0] |=>
            O_DATAPATH_RESET == $past(I_WDATA[1]);
    endproperty
    a_dpr: assert property (p_dpr) else $error("datapath reset");
    property p_clock_d_output;
        w2 |=> O_CLOCK_D_LOW_FREQ == ($past(I_WDATA[11]) & $past(I_WDATA[5]));
    endproperty
    a_clock_d_output: assert property (p_clock_d_output) else $error("clock d select");
    property p_cor; w2 |=> O_CLEAR_ON_READ == $past(I_WDATA[1]); endproperty
    a_cor: assert property (p_cor) else $error("clear policy");
    property p_irq; !O_IRQ_OUT |-> O_IRQ_OE; endproperty
    a_irq: assert property (p_irq) else $error("irq not driven");
    property p_pin; w3 |=> O_PIN_OE[7] == |$past(I_WDATA[15:14]); endproperty
    a_pin: assert property (p_pin) else $error("pin a4 drive");
    property p_err; O_ERROR_INSERT |=> !O_ERROR_INSERT; endproperty
    a_err: assert property (p_err) else $error("insert pulse");
    property p_upd; O_UPDATE_STROBE |=> !O_UPDATE_STROBE; endproperty
    a_upd: assert property (p_upd) else $error("update pulse");
    c_err: cover property (O_ERROR_INSERT);
    c_upd: cover property (O_UPDATE_STROBE);
    c_irq: cover property (!O_IRQ_OUT);
endmodule
bind global_control_registers glob_regs_chk u_chk (.*);

/* File: test/global_control_registers_tb.sv */
// Purpose: Self-checking bench of the global control register bank.
// Assumes: Inputs change at the falling edge of I_MCLK.
// Notes:   The second reference runs from a tick on every cycle.
module global_control_registers_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ********************
    // Bench signals, design and bus tasks.
    // ********************
    logic        I_MCLK = 1'h0, I_RST = 1'h1, I_CS = 1'h0, I_WR = 1'h0;
    logic        I_RD = 1'h0, I_PORTS_UPDATED = 1'h0;
    logic        O_IRQ_OUT, O_IRQ_OE, O_ERROR_INSERT, O_UPDATE_STROBE;
    logic        O_DATAPATH_RESET, O_GLOBAL_RESET, O_CLOCK_D_LOW_FREQ;
    logic        O_UPDATE_LEVEL, O_BROADCAST_WRITE;
    logic [2:0]  I_REF_TICK = 3'h0;
    logic [6:0]  O_CLOCK_ADAPTER;
    logic [3:0]  I_LOS = 4'h2, I_PORT_IRQ = 4'h0;
    logic [7:0]  I_PIN_IN = 8'h10, O_PIN_OUT, O_PIN_OE;
    logic [9:0]  I_ADDR = 10'h0;
    logic [15:0] I_WDATA = 16'h0, O_RDATA;
    int          failures = 0, checked = 0;
    global_control_registers dut (.*, .I_TX_TICK(4'h0),
        .I_CLOCK_ADAPTER_UNLOCK(1'h0), .O_CLEAR_ON_READ());
    always #50 I_MCLK = ~I_MCLK;
    task automatic chk(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Each access waits a fall first, so no signal moves twice at once.
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(negedge I_MCLK) {I_CS, I_WR, I_ADDR, I_WDATA} = {2'h3, a, d};
        @(negedge I_MCLK) {I_CS, I_WR} = 2'h0;
    endtask
    task automatic rdc(string n, logic [9:0] a, logic [15:0] m, e);
        @(negedge I_MCLK) {I_CS, I_RD, I_ADDR} = {2'h3, a};
        @(negedge I_MCLK) {I_CS, I_RD} = 2'h0;
        @(negedge I_MCLK) chk(n, O_RDATA & m, e);
    endtask
    // Counts trigger pulses over six cycles; exactly one is expected.
    task automatic count(input logic upd, input string n);
        int c;
        c = 0;
        repeat (6) begin
            @(negedge I_MCLK);
            if ((upd ? O_UPDATE_STROBE : O_ERROR_INSERT) === 1'h1) c++;
        end
        chk(n, 16'(c), 16'h1);
    endtask
    task automatic t_regs;
        rdc("cr1", 10'h002, 16'hFFFF, 16'h0002);
        wr(10'h000, 16'hFFFF);
        rdc("identity", 10'h000, 16'hFFFF, 16'h15A5);
        rdc("unmapped", 10'h006, 16'hFFFF, 16'h0000);
        wr(10'h004, 16'h7F33);
        rdc("cr2", 10'h004, 16'hFFFF, 16'h7F33);
        chk("clock d", 16'(O_CLOCK_D_LOW_FREQ), 16'h1);
        chk("cr2 out", {O_CLOCK_ADAPTER, 8'h0, O_BROADCAST_WRITE}, 16'hFE01);
        wr(10'h002, 16'h0001);
        chk("global reset", 16'(O_GLOBAL_RESET), 16'h1);
        wr(10'h002, 16'h0000);
        rdc("cr2 reset", 10'h004, 16'hFFFF, 16'h0000);
        $display("test registers done");
    endtask
    task automatic t_trig;
        repeat (2) begin
            wr(10'h002, 16'h0080);
            count(1'h0, "reg insert");
            wr(10'h002, 16'h0000);
        end
        wr(10'h002, 16'h0008);
        count(1'h1, "reg update");
        I_PORTS_UPDATED = 1'h1;
        rdc("complete", 10'h028, 16'hFFFF, 16'h0001);
        wr(10'h002, 16'h0000);
        rdc("complete low", 10'h028, 16'hFFFF, 16'h0000);
        rdc("latched set", 10'h02A, 16'hFFFF, 16'h0001);
        wr(10'h02A, 16'h0001);
        rdc("latched", 10'h02A, 16'hFFFF, 16'h0000);
        $display("test triggers done");
    endtask
    task automatic t_pins;
        wr(10'h010, 16'hE40F);
        wr(10'h002, 16'h0150);
        chk("pins", {O_PIN_OE, O_PIN_OUT[7:5], 5'h0}, 16'hE4A0);
        rdc("readback", 10'h038, 16'hFFFB, 16'h00B0);
        I_PIN_IN[1] = 1'h1;
        count(1'h0, "pin insert");
        I_PIN_IN[0] = 1'h1;
        count(1'h1, "pin update");
        $display("test pins done");
    endtask
    task automatic t_irq;
        I_PORT_IRQ = 4'h4;
        rdc("summary", 10'h020, 16'hFFFF, 16'h0008);
        chk("masked", 16'({O_IRQ_OE, O_IRQ_OUT}), 16'h1);
        wr(10'h022, 16'h0008);
        chk("active", 16'({O_IRQ_OE, O_IRQ_OUT}), 16'h2);
        wr(10'h022, 16'h0000);
        wr(10'h004, 16'h0010);
        chk("idle high", 16'({O_IRQ_OE, O_IRQ_OUT}), 16'h3);
        $display("test interrupt done");
    endtask
    // Tick each cycle; the bound covers one full divider period.
    task automatic t_sec;
        int k;
        wr(10'h002, 16'h0320);
        wr(10'h004, 16'h0012);
        I_REF_TICK = 3'h1;
        for (k = 0; k < 1100 && O_PIN_OUT[2] !== 1'h1; k++)
            @(negedge I_MCLK);
        chk("second out", 16'(k < 1100), 16'h1);
        chk("update level", 16'(O_UPDATE_LEVEL), 16'h1);
        count(1'h1, "second update");
        rdc("second latched", 10'h02A, 16'h0006, 16'h0002);
        rdc("read clear", 10'h02A, 16'h0006, 16'h0000);
        $display("test second done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge I_MCLK);
        I_RST = 1'h0;
        t_regs;
        t_trig;
        t_pins;
        t_irq;
        t_sec;
        tally_and_finish;
    end
endmodule
